// [sfp_module_control_status.sv]
// Module control and status: laser enable, eye safety, signal loss, serial id
`timescale 1ns/100ps
module sfp_module_control_status (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tx_disable,
  input wire sfp_ctl_pkg::safety_sense_t sense,
  input wire logic rx_power_low,
  output logic laser_enable,
  output logic tx_fault,
  output logic receive_signal_lost,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic id_wr_en,
  input wire logic [6:0] id_wr_addr,
  input wire logic [7:0] id_wr_data
);
  import sfp_ctl_pkg::*;

  logic fault_latched;
  logic unsafe;
  logic [LOS_CW-1:0] los_cnt;
  logic [7:0] id_mem [ID_DEPTH];
  logic scl_q;
  logic sda_q;
  tw_state_t tw_state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [ID_AW-1:0] ptr;
  logic rd_mode;
  logic nack_seen;

  assign unsafe = |sense;

  // Fault latch; sets only while tx_disable is low, so a trip during disable does not latch; tx_disable high clears it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_latched <= 1'b0;
    end else if (unsafe && !tx_disable) begin
      fault_latched <= 1'b1;
    end else if (tx_disable) begin
      fault_latched <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      laser_enable <= 1'b0;
      tx_fault <= 1'b0;
    end else begin
      laser_enable <= !tx_disable && !unsafe && !fault_latched;
      // Tracks the latch's next value, so a one-cycle disable pulse clears it at once
      tx_fault <= (fault_latched || unsafe) && !tx_disable;
    end
  end

  // Signal-lost with hysteresis so short dips do not flag a fault
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      los_cnt <= '0;
      receive_signal_lost <= 1'b1;
    end else if (rx_power_low != receive_signal_lost) begin
      if (rx_power_low && los_cnt == LOS_CW'(LOS_ASSERT_CYC - 1)) begin
        receive_signal_lost <= 1'b1;
        los_cnt <= '0;
      end else if (!rx_power_low && los_cnt == LOS_CW'(LOS_DEASSERT_CYC - 1)) begin
        receive_signal_lost <= 1'b0;
        los_cnt <= '0;
      end else begin
        los_cnt <= los_cnt + 1'b1;
      end
    end else begin
      los_cnt <= '0;
    end
  end

  // Factory programming port for the id contents
  always_ff @(posedge clk) begin
    if (id_wr_en) begin
      id_mem[id_wr_addr] <= id_wr_data;
    end
  end

  // Two-wire pins treated as synchronous; edges seen against last sample
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  wire scl_rise = scl && !scl_q;
  wire scl_fall = !scl && scl_q;
  wire start_c = scl && scl_q && sda_q && !sda_in;
  wire stop_c = scl && scl_q && !sda_q && sda_in;

  // Serial memory slave: random read via dummy write, sequential reads; written bytes are not stored, each is acked and reloads ptr
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tw_state <= TW_IDLE;
      bit_cnt <= '0;
      shreg <= '0;
      ptr <= '0;
      rd_mode <= 1'b0;
      nack_seen <= 1'b0;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      tw_state <= TW_ADDR;
      bit_cnt <= '0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      tw_state <= TW_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (tw_state)
        TW_IDLE: begin
          sda_oe <= 1'b0;
        end
        TW_ADDR, TW_WORD: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_in};
            bit_cnt <= bit_cnt + 1'b1;
          end
          if (scl_fall && bit_cnt == BIT_ACK) begin
            bit_cnt <= '0;
            if (tw_state == TW_WORD) begin
              ptr <= shreg[ID_AW-1:0];
              sda_oe <= 1'b1;
              sda_out <= 1'b0;
              tw_state <= TW_WORD_ACK;
            end else if (shreg[7:1] == DEV_ADDR) begin
              rd_mode <= shreg[0];
              sda_oe <= 1'b1;
              sda_out <= 1'b0;
              tw_state <= TW_ADDR_ACK;
            end else begin
              tw_state <= TW_IDLE;
            end
          end
        end
        TW_ADDR_ACK, TW_WORD_ACK: begin
          if (scl_fall) begin
            if (tw_state == TW_ADDR_ACK && rd_mode) begin
              shreg <= id_mem[ptr];
              sda_out <= id_mem[ptr][7];
              sda_oe <= !id_mem[ptr][7];
              bit_cnt <= '0;
              tw_state <= TW_READ;
            end else begin
              sda_oe <= 1'b0;
              tw_state <= TW_WORD;
            end
          end
        end
        TW_READ: begin
          if (scl_fall) begin
            if (bit_cnt == BIT_LAST) begin
              sda_oe <= 1'b0;
              ptr <= ptr + 1'b1;
              tw_state <= TW_READ_ACK;
            end else begin
              bit_cnt <= bit_cnt + 1'b1;
              shreg <= {shreg[6:0], 1'b0};
              sda_out <= shreg[6];
              sda_oe <= !shreg[6];
            end
          end
        end
        TW_READ_ACK: begin
          if (scl_rise) begin
            nack_seen <= sda_in;
          end
          if (scl_fall) begin
            if (nack_seen) begin
              tw_state <= TW_IDLE;
            end else begin
              shreg <= id_mem[ptr];
              sda_out <= id_mem[ptr][7];
              sda_oe <= !id_mem[ptr][7];
              bit_cnt <= '0;
              tw_state <= TW_READ;
            end
          end
        end
      endcase
    end
  end

  a_laser_off_disable: assert property (@(posedge clk) disable iff (!nrst)
    tx_disable |=> !laser_enable) else $error("laser on while disabled");
  a_fault_on_unsafe: assert property (@(posedge clk) disable iff (!nrst)
    unsafe && !tx_disable |=> tx_fault && !laser_enable) else $error("unsafe without fault");
  a_fault_holds: assert property (@(posedge clk) disable iff (!nrst)
    tx_fault && !tx_disable |=> tx_fault) else $error("fault dropped without cycling");
  a_fault_clears: assert property (@(posedge clk) disable iff (!nrst)
    tx_disable [*2] ##1 !tx_disable && !unsafe |=> !tx_fault) else $error("fault not cleared");
  a_resume_tx: assert property (@(posedge clk) disable iff (!nrst)
    !tx_disable && !unsafe && !fault_latched |=> laser_enable) else $error("laser not resumed");
  a_los_filter: assert property (@(posedge clk) disable iff (!nrst)
    $rose(receive_signal_lost) |-> $past(rx_power_low, 3) && $past(rx_power_low, 1)) else $error("loss too fast");
  a_los_clear: assert property (@(posedge clk) disable iff (!nrst)
    $fell(receive_signal_lost) |-> !$past(rx_power_low)) else $error("loss cleared while low");
  a_sda_drive_low: assert property (@(posedge clk) disable iff (!nrst)
    sda_oe |-> !sda_out) else $error("sda driven high");
  c_fault_trip: cover property (@(posedge clk) disable iff (!nrst) $rose(tx_fault));
  c_fault_reset: cover property (@(posedge clk) disable iff (!nrst) $fell(tx_fault));
  c_los_set: cover property (@(posedge clk) disable iff (!nrst) $rose(receive_signal_lost));
  c_id_read: cover property (@(posedge clk) disable iff (!nrst) tw_state == TW_READ_ACK);
endmodule : sfp_module_control_status

// [sfp_ctl_pkg.sv]
// Shared types and constants for the module control and status block
package sfp_ctl_pkg;
  // Serial id memory geometry and two-wire protocol
  localparam int unsigned ID_DEPTH = 128;
  localparam int unsigned ID_AW = 7;
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Loss-of-signal filter: times in ns, counts derived from 5 ns clock
  localparam int unsigned CLK_NS = 5;
  localparam int unsigned LOS_ASSERT_NS = 2000;
  localparam int unsigned LOS_DEASSERT_NS = 1000;
  localparam int unsigned LOS_ASSERT_CYC = (LOS_ASSERT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LOS_DEASSERT_CYC = LOS_DEASSERT_NS / CLK_NS;
  localparam int unsigned LOS_CW = 9;

  // Analogue sense inputs from the optical front end
  typedef struct packed {
    logic power_unsafe;
    logic supply_glitch;
    logic code_unbalanced;
    logic internal_fault;
  } safety_sense_t;

  // Two-wire pin triple, open drain
  typedef struct packed {
    logic din;
    logic dout;
    logic oe;
  } sda_pin_t;

  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_ADDR_ACK, TW_WORD, TW_WORD_ACK, TW_READ, TW_READ_ACK
  } tw_state_t;
endpackage : sfp_ctl_pkg

// [sfp_host_model.sv]
// Host two-wire controller model for the id memory
`timescale 1ns/100ps
module sfp_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  initial begin
    scl = 1'h1;
    sda_oe = 1'h0;
  end
  // Four clocks per phase, well above the two the block needs
  task automatic ph(input logic c, input logic o);
    repeat (4) @(posedge clk);
    #1;
    scl = c;
    sda_oe = o;
  endtask : ph
  task automatic start;
    ph(1'h0, 1'h0);
    ph(1'h1, 1'h0);
    ph(1'h1, 1'h1);
    ph(1'h0, 1'h1);
  endtask : start
  task automatic stop;
    ph(1'h0, 1'h1);
    ph(1'h1, 1'h1);
    ph(1'h1, 1'h0);
  endtask : stop
  // Sample mid high phase, data held through the falling edge
  task automatic bit_x(input logic b, output logic r);
    ph(1'h0, !b);
    ph(1'h1, !b);
    repeat (2) @(posedge clk);
    #1;
    r = sda;
    ph(1'h0, !b);
  endtask : bit_x
  // Send FF to read; ack_in 1 releases the ninth bit
  task automatic xfer(input logic [7:0] w, input logic ack_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
    bit_x(ack_in, ack);
  endtask : xfer
endmodule : sfp_host_model

// [sfp_module_control_status_tb_top.sv]
// Self-checking bench for the module control and status block
`timescale 1ns/100ps
module sfp_module_control_status_tb_top;
  import sfp_ctl_pkg::*;
  logic clk = 1'h0, nrst = 1'h0, tx_disable = 1'h0, rx_power_low = 1'h0, id_wr_en = 1'h0;
  safety_sense_t sense = '0;
  logic [6:0] id_wr_addr = '0;
  logic [7:0] id_wr_data = '0;
  logic laser_enable, tx_fault, receive_signal_lost, sda_out, sda_oe, scl, host_oe, sda, ak;
  logic [7:0] rd;
  int bad_count = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  // Pull-up on the wire, either side may pull low
  assign sda = !(host_oe || (sda_oe && !sda_out));
  sfp_module_control_status sfp_module_control_status_inst (.clk(clk), .nrst(nrst), .tx_disable(tx_disable),
    .sense(sense), .rx_power_low(rx_power_low), .laser_enable(laser_enable), .tx_fault(tx_fault),
    .receive_signal_lost(receive_signal_lost), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .id_wr_en(id_wr_en), .id_wr_addr(id_wr_addr), .id_wr_data(id_wr_data));
  sfp_host_model sfp_host_model_inst (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic t_los;
    cyc(195);
    check("los_hold", receive_signal_lost, 8'h1);
    cyc(10);
    check("los_clear", receive_signal_lost, 8'h0);
    rx_power_low = 1'h1;
    cyc(395);
    check("los_filter", receive_signal_lost, 8'h0);
    cyc(10);
    check("los_set", receive_signal_lost, 8'h1);
    rx_power_low = 1'h0;
  endtask : t_los
  task automatic t_laser;
    check("laser_on", laser_enable, 8'h1);
    tx_disable = 1'h1;
    cyc(2);
    check("laser_off", laser_enable, 8'h0);
    tx_disable = 1'h0;
    cyc(2);
  endtask : t_laser
  // Each unsafe source in turn, cleared by cycling disable
  task automatic t_fault;
    for (int i = 0; i < 4; i++) begin
      sense = safety_sense_t'(4'h1 << i);
      cyc(2);
      check("fault_set", {tx_fault, laser_enable}, 8'h2);
      sense = '0;
      cyc(5);
      check("fault_held", {tx_fault, laser_enable}, 8'h2);
      tx_disable = 1'h1;
      cyc(2);
      check("fault_clr", tx_fault, 8'h0);
      tx_disable = 1'h0;
      cyc(2);
      check("resume", laser_enable, 8'h1);
    end
  endtask : t_fault
  // Read across the top of memory to see the pointer wrap
  task automatic t_id;
    id_wr_en = 1'h1;
    for (int i = 0; i < 3; i++) begin
      id_wr_addr = 7'h7E + 7'(i);
      id_wr_data = 8'hA0 + 8'(i);
      cyc(1);
    end
    id_wr_en = 1'h0;
    sfp_host_model_inst.start();
    sfp_host_model_inst.xfer(8'hA2, 1'h1, rd, ak);
    check("bad_dev_nack", ak, 8'h1);
    sfp_host_model_inst.stop();
    sfp_host_model_inst.start();
    sfp_host_model_inst.xfer(8'hA0, 1'h1, rd, ak);
    check("dev_ack", ak, 8'h0);
    sfp_host_model_inst.xfer(8'h7E, 1'h1, rd, ak);
    check("word_ack", ak, 8'h0);
    sfp_host_model_inst.start();
    sfp_host_model_inst.xfer(8'hA1, 1'h1, rd, ak);
    check("rd_ack", ak, 8'h0);
    for (int i = 0; i < 3; i++) begin
      sfp_host_model_inst.xfer(8'hFF, i == 2, rd, ak);
      check("id_byte", rd, 8'hA0 + 8'(i));
    end
    sfp_host_model_inst.stop();
  endtask : t_id
  // Unsafe while disabled must not latch; a one-cycle disable pulse clears a fault
  task automatic t_refuse;
    tx_disable = 1'h1;
    sense = safety_sense_t'(4'h8);
    cyc(2);
    sense = '0;
    tx_disable = 1'h0;
    cyc(2);
    check("no_latch", {tx_fault, laser_enable}, 8'h1);
    sense = safety_sense_t'(4'h8);
    cyc(1);
    check("pulse_trip", {tx_fault, laser_enable}, 8'h2);
    sense = '0;
    tx_disable = 1'h1;
    cyc(1);
    tx_disable = 1'h0;
    cyc(2);
    check("pulse_clr", {tx_fault, laser_enable}, 8'h1);
  endtask : t_refuse
  // Mid-run reset stands in for a power cycle and must drop a latched fault
  task automatic t_reset;
    sense = safety_sense_t'(4'h4);
    cyc(1);
    sense = '0;
    cyc(3);
    check("latch_pre_rst", {tx_fault, laser_enable}, 8'h2);
    nrst = 1'h0;
    cyc(2);
    check("rst_mid", {laser_enable, tx_fault, receive_signal_lost, sda_oe}, 8'h2);
    nrst = 1'h1;
    cyc(2);
    check("rst_resume", {tx_fault, laser_enable, receive_signal_lost}, 8'h3);
  endtask : t_reset
  initial begin
    cyc(4);
    check("rst", {laser_enable, tx_fault, receive_signal_lost, sda_oe}, 8'h2);
    nrst = 1'h1;
    cyc(2);
    t_los();
    t_laser();
    t_fault();
    t_id();
    t_refuse();
    t_reset();
    finish_test();
  end
  // Hang guard, well past the longest sequence
  initial begin
    #400us;
    bad_count++;
    finish_test();
  end
endmodule : sfp_module_control_status_tb_top
